/* File: hw/crs_pkg.sv */
// Purpose: shared constants and types for the cpu register/stack block
// Assumes: 4-bit data digits, 10-bit data addresses, 14-bit code addresses
// Notes:   control-bit index is digit*4+bit across digits 000..003
package crs_pkg;

  // program memory map
  localparam int        PC_W       = 14;
  localparam logic [13:0] RESET_VEC = 14'h0000;
  localparam logic [13:0] VEC_LAST  = 14'h000F;
  localparam logic [13:0] ZP_LAST   = 14'h003F;
  localparam logic [13:0] PAT_LAST  = 14'h0FFF;
  localparam logic [13:0] PROG_LAST = 14'h3FFF;

  // data memory map
  localparam logic [9:0] ICB_DIGIT0 = 10'h000;
  localparam logic [9:0] ICB_DIGIT1 = 10'h001;
  localparam logic [9:0] ICB_DIGIT2 = 10'h002;
  localparam logic [9:0] ICB_DIGIT3 = 10'h003;
  localparam logic [9:0] SFR_FIRST  = 10'h004;
  localparam logic [9:0] SFR_LAST   = 10'h00B;
  localparam logic [9:0] DATA_FIRST = 10'h020;
  localparam logic [9:0] MR_LAST    = 10'h02F;
  localparam logic [9:0] DATA_LAST  = 10'h3BF;
  localparam logic [9:0] STK_FIRST  = 10'h3C0;
  localparam logic [9:0] SP_RST     = 10'h3FF;
  localparam logic [3:0] SP_HI      = 4'hF;
  localparam logic [9:0] SP_STEP    = 10'h004;

  // control-bit positions and reset pattern (masks 1, rest 0)
  localparam logic [3:0]  CTL_IE   = 4'h0;
  localparam logic [3:0]  CTL_RSP  = 4'h1;
  localparam logic [15:0] CTL_RST  = 16'h22A8;
  localparam logic [15:0] CTL_FLAG = 16'h1154;
  localparam logic [15:0] CTL_USED = 16'h33FF;

  // working register select codes
  typedef enum logic [2:0] {
    CRS_R_ACC = 3'h0, CRS_R_B = 3'h1, CRS_R_W = 3'h2, CRS_R_X = 3'h3,
    CRS_R_Y = 3'h4, CRS_R_SPX = 3'h5, CRS_R_SPY = 3'h6
  } crs_reg_t;

  // interrupt entry sequence
  typedef enum logic [2:0] {
    CRS_S_IDLE = 3'b001, CRS_S_SAVE = 3'b010, CRS_S_JUMP = 3'b100
  } crs_state_t;

  // stack frame: digit0..2 = pc, digit3 = {status, carry, pc[13:12]}
  function automatic logic [15:0] crs_frame(input logic [13:0] pc,
                                            input logic st,
                                            input logic ca);
    crs_frame = {st, ca, pc};
  endfunction

endpackage

/* File: hw/crs_stack_ptr.sv */
// Purpose: stack pointer with fixed upper bits and sixteen levels
// Assumes: caller never pushes or pops together with a reinitialise
// Notes:   pointer reads {1111, level, 11}; pop base tracked as a flop
`timescale 1ns/1ps
module crs_stack_ptr
  import crs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  input  wire logic       push,
  input  wire logic       pop,
  input  wire logic       reinit,
  output logic [9:0]      stack_pointer,
  output logic [9:0]      pop_base
);

  logic [3:0] lvl_r;
  logic [3:0] up_r;
  logic [3:0] lvl_nxt;

  // level steps down on push, up on pop; reinit wins
  assign lvl_nxt = reinit ? SP_HI :
                   push   ? lvl_r - 4'h1 :
                   pop    ? lvl_r + 4'h1 : lvl_r;

  assign stack_pointer = {SP_HI, lvl_r, 2'b11};
  assign pop_base      = {SP_HI, up_r, 2'b00};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_r <= 4'hF;
      up_r  <= 4'h0;
    end
    else if (clk_en)
    begin
      lvl_r <= lvl_nxt;
      up_r  <= lvl_nxt + 4'h1;
    end
  end

endmodule

/* File: hw/crs_int_ctrl.sv */
// Purpose: interrupt control bits held in data digits 000..003
// Assumes: bit strobes arrive only for addresses inside that area
// Notes:   hardware set of a request flag wins over a software clear
`timescale 1ns/1ps
module crs_int_ctrl
  import crs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        bit_set,
  input  wire logic        bit_clr,
  input  wire logic [3:0]  bit_idx,
  input  wire logic [4:0]  hw_req,
  input  wire logic        irq_ack,
  input  wire logic        irq_ret,
  output logic [15:0]      ctl
);

  logic [15:0] ctl_r;
  logic [15:0] sel;
  logic [15:0] hw_set;
  logic [15:0] ctl_nxt;

  assign sel    = 16'h0001 << bit_idx;
  // request flags: ext0, ext1, timer a, timer b, serial
  assign hw_set = {3'h0, hw_req[4], 3'h0, hw_req[3], 1'b0, hw_req[2],
                   1'b0, hw_req[1], 1'b0, hw_req[0], 2'h0};

  // bit strobes, IE cleared on entry and set on return, hardware requests; set never raises a request flag
  assign ctl_nxt = (((ctl_r | (bit_set ? sel & ~CTL_FLAG : 16'h0000))
                    & ~(bit_clr ? sel : 16'h0000)
                    & ~(irq_ack ? 16'h0001 : 16'h0000))
                    | (irq_ret ? 16'h0001 : 16'h0000)
                    | hw_set) & CTL_USED;

  assign ctl = ctl_r;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_r <= CTL_RST;
    else if (clk_en)
      ctl_r <= ctl_nxt;
  end

  property p_no_sw_flag_set;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && bit_set && CTL_FLAG[bit_idx] && !ctl_r[bit_idx]
     && hw_set == 16'h0000) |=> !ctl_r[$past(bit_idx)];
  endproperty
  a_no_sw_flag_set: assert property (p_no_sw_flag_set)
    else $error("software raised a request flag");

  property p_hw_set_wins;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && hw_req[0]) |=> ctl_r[2];
  endproperty
  a_hw_set_wins: assert property (p_hw_set_wins)
    else $error("hardware request lost against a clear");

endmodule

/* File: hw/crs_core_regs.sv */
// Purpose: program counter, working registers, flags, stack and maps
// Assumes: sequencer gives one-cycle strobes, one operation per cycle
// Notes:   stack ram lives outside; frames move as 16-bit words
`timescale 1ns/1ps

// Notes on behaviour
// - 14-bit binary program counter steps through program memory
// - reset and interrupts start at vectors 0000..000F
// - short call lands only inside 0000..003F
// - pattern reads allowed up to 0FFF; code may fill 0000..3FFF
// - digits 000..003 are bit-op only; software never sets requests
// - digits 004..00B are special registers; bit ops refused there
// - data 020..3BF; memory registers 020..02F via load/exchange
// - stack 3C0..3FF, sixteen four-digit frames of pc, status, carry
// - sub return restores pc only; interrupt return also flags
// - digit 0: enable, stack reset, ext0 flag/mask; digit 1 ext1/timer a
// - digit 2 timer b flag/mask; digit 3 serial flag/mask; rest unused
// - control bits change only by bit ops; set leaves requests alone; here hardware also sets flags, entry clears and return sets enable
// - testing an unused control bit leaves status undefined
// - accumulator and b register take alu results and transfers
// - w, x, y form indirect address; y also picks port pin
// - two auxiliary registers pair with x and y
// - carry from alu overflow and set, clear, rotate operations
// - interrupt entry pushes carry and status with program counter
// - status holds alu or test result until next such instruction
// - status forced to one after any branch or call; this block forces it on branch_done only, calls leave it
// - stack pointer starts 3FF, minus four on push, plus four on pop
// - upper four pointer bits fixed at 1111
// - pointer reinitialised by reset or clearing stack reset bit
// - reset clears enable and requests, sets all masks
module crs_core_regs
  import crs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        pc_step,
  input  wire logic        pc_jump,
  input  wire logic        call_short,
  input  wire logic        call_long,
  input  wire logic [13:0] pc_target,
  input  wire logic        sub_return,
  input  wire logic        irq_return,
  input  wire logic [15:0] stack_rdata,
  input  wire logic        irq_take,
  input  wire logic [3:0]  irq_vector,
  input  wire logic [4:0]  irq_event,
  input  wire logic        reg_we,
  input  wire logic [2:0]  reg_sel,
  input  wire logic [3:0]  reg_wdata,
  input  wire logic        swap_x_aux,
  input  wire logic        swap_y_aux,
  input  wire logic        carry_we,
  input  wire logic        carry_val,
  input  wire logic        set_carry_op,
  input  wire logic        clear_carry_op,
  input  wire logic        status_we,
  input  wire logic        status_val,
  input  wire logic        branch_done,
  input  wire logic        bit_set_op,
  input  wire logic        bit_reset_op,
  input  wire logic        bit_test_op,
  input  wire logic [9:0]  bit_addr,
  input  wire logic [1:0]  bit_pos,
  input  wire logic        pat_req,
  input  wire logic [13:0] pat_addr,
  input  wire logic        memreg_req,
  input  wire logic [3:0]  memreg_idx,
  output logic [13:0]      program_counter,
  output logic [9:0]       stack_pointer,
  output logic [9:0]       stack_pop_base,
  output logic             stack_we,
  output logic [9:0]       stack_wbase,
  output logic [15:0]      stack_wdata,
  output logic             status_flag,
  output logic             carry_flag,
  output logic [3:0]       acc,
  output logic [3:0]       breg,
  output logic [9:0]       ind_addr,
  output logic [3:0]       port_pin_sel,
  output logic [3:0]       aux_index_lo,
  output logic [3:0]       aux_index_hi,
  output logic [15:0]      int_ctrl_bits,
  output logic             irq_pending,
  output logic             bit_refused,
  output logic             pat_ok,
  output logic             memreg_valid,
  output logic [9:0]       memreg_addr
);

  logic [13:0] pc_r, pc_nxt;
  logic        st_r, st_nxt;
  logic        ca_r, ca_nxt;
  logic [3:0]  acc_r, b_r, x_r, y_r, spx_r, spy_r, vec_r, bit_idx;
  logic [1:0]  w_r;
  crs_state_t  state_r, state_nxt;
  logic [9:0]  stack_wbase_r, memreg_addr_r, sp;
  logic [15:0] stack_wdata_r, ctl;
  logic        irq_pending_r, bit_refused_r, pat_ok_r, memreg_valid_r;
  logic        in_icb, in_sfr, icb_set, icb_clr, test_used, rsp_clr;
  logic        push, pop, save, stack_we_r;

  // data map decode
  assign in_icb  = bit_addr <= ICB_DIGIT3;
  assign in_sfr  = (bit_addr >= SFR_FIRST) && (bit_addr <= SFR_LAST);
  assign bit_idx = {bit_addr[1:0], bit_pos};
  assign icb_set = bit_set_op && in_icb;
  assign icb_clr = bit_reset_op && in_icb;
  assign rsp_clr   = icb_clr && (bit_idx == CTL_RSP);
  // unused bits give no defined result
  assign test_used = bit_test_op && in_icb && CTL_USED[bit_idx];

  // stack traffic
  assign save = (state_r == CRS_S_SAVE);
  assign push = call_short || call_long || save;
  assign pop  = sub_return || irq_return;

  crs_stack_ptr u_sp (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .clk_en        (clk_en),
    .push          (push),
    .pop           (pop),
    .reinit        (rsp_clr),
    .stack_pointer (sp),
    .pop_base      (stack_pop_base)
  );
  crs_int_ctrl u_ic (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .bit_set  (icb_set),
    .bit_clr  (icb_clr),
    .bit_idx  (bit_idx),
    .hw_req   (irq_event),
    .irq_ack  (save),
    .irq_ret  (irq_return),
    .ctl      (ctl)
  );

  // interrupt entry: take, save (IE off, push), jump to vector
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      CRS_S_IDLE: if (irq_take) state_nxt = CRS_S_SAVE;
      CRS_S_SAVE: state_nxt = CRS_S_JUMP;
      CRS_S_JUMP: state_nxt = CRS_S_IDLE;
      default:    state_nxt = CRS_S_IDLE;
    endcase
  end

  assign pc_nxt = (state_r == CRS_S_JUMP) ? {10'h000, vec_r} & VEC_LAST :
                  pop        ? stack_rdata[13:0] :
                  call_short ? pc_target & ZP_LAST :
                  (pc_jump || call_long) ? pc_target & PROG_LAST :
                  pc_step    ? pc_r + 14'h0001 : pc_r;
  assign st_nxt = irq_return  ? stack_rdata[15] :
                  branch_done ? 1'b1 :
                  test_used   ? ctl[bit_idx] :
                  status_we   ? status_val : st_r;

  // carry: restore, set, clear, alu or rotate
  assign ca_nxt = irq_return     ? stack_rdata[14] :
                  set_carry_op   ? 1'b1 :
                  clear_carry_op ? 1'b0 :
                  carry_we       ? carry_val : ca_r;

  // sequencer state and program counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= CRS_S_IDLE;
      pc_r    <= RESET_VEC;
      vec_r   <= 4'h0;
    end
    else if (clk_en)
    begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      if (irq_take && state_r == CRS_S_IDLE)
        vec_r <= irq_vector;
    end
  end

  // flags
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= 1'b1;
      ca_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      ca_r <= ca_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {acc_r, b_r, x_r, y_r, spx_r, spy_r} <= 24'h000000;
      w_r <= 2'h0;
    end
    else if (clk_en)
    begin
      if (reg_we && reg_sel == CRS_R_ACC) acc_r <= reg_wdata;
      if (reg_we && reg_sel == CRS_R_B)   b_r   <= reg_wdata;
      if (reg_we && reg_sel == CRS_R_W)   w_r   <= reg_wdata[1:0];
      if (swap_x_aux)
      begin
        x_r   <= spx_r;
        spx_r <= x_r;
      end
      else
      begin
        if (reg_we && reg_sel == CRS_R_X)   x_r   <= reg_wdata;
        if (reg_we && reg_sel == CRS_R_SPX) spx_r <= reg_wdata;
      end
      if (swap_y_aux)
      begin
        y_r   <= spy_r;
        spy_r <= y_r;
      end
      else
      begin
        if (reg_we && reg_sel == CRS_R_Y)   y_r   <= reg_wdata;
        if (reg_we && reg_sel == CRS_R_SPY) spy_r <= reg_wdata;
      end
    end
  end

  // frame write: four digits ending at the pointer (pointer minus three up to pointer)
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stack_we_r    <= 1'b0;
      stack_wbase_r <= STK_FIRST;
      stack_wdata_r <= 16'h0000;
    end
    else if (clk_en)
    begin
      stack_we_r <= push;
      if (push)
      begin
        stack_wbase_r <= sp - 10'h003;
        stack_wdata_r <= crs_frame(pc_r, st_r, ca_r);
      end
    end
  end

  // map checks and irq request level
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_pending_r  <= 1'b0;
      bit_refused_r  <= 1'b0;
      pat_ok_r       <= 1'b0;
      memreg_valid_r <= 1'b0;
      memreg_addr_r  <= DATA_FIRST;
    end
    else if (clk_en)
    begin
      irq_pending_r  <= ctl[CTL_IE] &&
                        |(ctl & CTL_FLAG & ~(ctl >> 1)); // mask above flag
      bit_refused_r  <= (bit_set_op || bit_reset_op || bit_test_op)
                        && in_sfr;
      pat_ok_r       <= pat_req && (pat_addr <= PAT_LAST);
      memreg_valid_r <= memreg_req;
      if (memreg_req)
        memreg_addr_r <= (DATA_FIRST | {6'h00, memreg_idx}) & MR_LAST;
    end
  end

  assign program_counter = pc_r;
  assign stack_pointer   = sp;
  assign stack_we        = stack_we_r;
  assign stack_wbase     = stack_wbase_r;
  assign stack_wdata     = stack_wdata_r;
  assign status_flag     = st_r;
  assign carry_flag      = ca_r;
  assign acc             = acc_r;
  assign breg            = b_r;
  assign ind_addr        = {w_r, x_r, y_r};
  assign port_pin_sel    = y_r;
  assign aux_index_lo    = spx_r;
  assign aux_index_hi    = spy_r;
  assign int_ctrl_bits   = ctl;
  assign irq_pending     = irq_pending_r;
  assign bit_refused     = bit_refused_r;
  assign pat_ok          = pat_ok_r;
  assign memreg_valid    = memreg_valid_r;
  assign memreg_addr     = memreg_addr_r;

  sequence s_enter;
    clk_en && irq_take && state_r == CRS_S_IDLE;
  endsequence
  sequence s_saved;
    clk_en && stack_we_r && !int_ctrl_bits[0];
  endsequence
  property p_irq_entry;
    @(posedge core_clk) disable iff (!rst_n)
    s_enter ##1 clk_en |=> s_saved ##0 stack_wdata_r[15] == $past(st_r);
  endproperty
  a_irq_entry: assert property (p_irq_entry)
    else $error("interrupt entry did not save flags");
  property p_vector;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && state_r == CRS_S_JUMP) |=> pc_r == {10'h000, $past(vec_r)};
  endproperty
  a_vector: assert property (p_vector)
    else $error("pc not at vector after entry");
  property p_push_step;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && push && !rsp_clr && sp != STK_FIRST + 10'h003)
      |=> sp == $past(sp) - SP_STEP;
  endproperty
  a_push_step: assert property (p_push_step)
    else $error("push did not lower pointer by four");
  property p_rsp;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && rsp_clr) |=> sp == SP_RST;
  endproperty
  a_rsp: assert property (p_rsp)
    else $error("pointer not reinitialised");
  property p_branch_st;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && branch_done && !irq_return) |=> st_r;
  endproperty
  a_branch_st: assert property (p_branch_st)
    else $error("status not one after branch");
  property p_sub_ret;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && sub_return && !branch_done && !status_we && !test_used)
      |=> st_r == $past(st_r) && pc_r == $past(stack_rdata[13:0]);
  endproperty
  a_sub_ret: assert property (p_sub_ret)
    else $error("sub return disturbed status or pc");
  property p_short_call;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && call_short && !pop && state_r != CRS_S_JUMP)
      |=> pc_r <= ZP_LAST;
  endproperty
  a_short_call: assert property (p_short_call)
    else $error("short call left zero page");
  property p_sfr_refuse;
    @(posedge core_clk) disable iff (!rst_n)
    (clk_en && bit_set_op && in_sfr && irq_event == 5'h00)
      |=> bit_refused_r && int_ctrl_bits == $past(int_ctrl_bits);
  endproperty
  a_sfr_refuse: assert property (p_sfr_refuse)
    else $error("bit op reached special registers");

endmodule

/* File: verif/crs_stack_ram_model.sv */
// Purpose: stack memory standing behind the register block's frame port
// Assumes: frames arrive whole as 16-bit words, one per level
// Notes:   levels never written read a toggling pattern, not zero
`timescale 1ns/1ps
module crs_stack_ram_model
(
  input  wire logic        core_clk,
  input  wire logic        stack_we,
  input  wire logic [9:0]  stack_wbase,
  input  wire logic [15:0] stack_wdata,
  input  wire logic [9:0]  stack_pop_base,
  output logic [15:0]      stack_rdata
);
  logic [15:0] mem_r [16];

  // fill levels with a pattern so a stale read is not silently zero
  initial
  begin
    for (int i = 0; i < 16; i++)
      mem_r[i] = i[0] ? 16'h5A5A : 16'hA5A5;
  end

  always @(posedge core_clk)
  begin
    if (stack_we)
      mem_r[stack_wbase[5:2]] <= stack_wdata;
  end

  // frame at the pop base, valid in the pop cycle
  assign stack_rdata = mem_r[stack_pop_base[5:2]];
endmodule

/* File: verif/cpu_regs_stack_memmap_tb_top.sv */
// Purpose: self-checking bench for the cpu register and stack block
// Assumes: inputs change at the falling edge, one operation per op slot
// Notes:   expectations are tracked in bench state, never read back
`timescale 1ns/1ps
module cpu_regs_stack_memmap_tb_top;
  import crs_pkg::*;
  logic        core_clk, rst_n, clk_en, pc_step, pc_jump, call_short;
  logic        call_long, sub_return, irq_return, irq_take, reg_we;
  logic        swap_x_aux, swap_y_aux, carry_we, carry_val, set_carry_op;
  logic        clear_carry_op, status_we, status_val, branch_done;
  logic        bit_set_op, bit_reset_op, bit_test_op, pat_req, memreg_req;
  logic        stack_we, status_flag, carry_flag, irq_pending, bit_refused;
  logic        pat_ok, memreg_valid, est, eca;
  logic [13:0] pc_target, pat_addr, program_counter, epc;
  logic [15:0] stack_rdata, stack_wdata, int_ctrl_bits, ectl;
  logic [3:0]  irq_vector, reg_wdata, memreg_idx, acc, breg;
  logic [3:0]  port_pin_sel, aux_index_lo, aux_index_hi;
  logic [4:0]  irq_event;
  logic [2:0]  reg_sel;
  logic [9:0]  bit_addr, stack_pointer, stack_pop_base, stack_wbase;
  logic [9:0]  ind_addr, memreg_addr, esp;
  logic [1:0]  bit_pos;
  logic [15:0] frames [$];
  logic [3:0]  er [7];
  int          fail_count, checked;

  crs_core_regs u_crs_core_regs (.*);
  crs_stack_ram_model u_crs_stack_ram_model (.*);

  // free-running core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // expected frame layout and pointer steps
  function automatic logic [15:0] exp_frame(logic [13:0] pc, logic s, c);
    return {s, c, pc};
  endfunction
  function automatic logic [9:0] sp_dn(logic [9:0] s);
    return {4'hF, 6'(s[5:0] - 6'h04)};
  endfunction
  function automatic logic [15:0] ctl_after(int k, logic [15:0] c,
                                            logic [3:0] i);
    logic used;
    logic flag;
    used = ((16'h33FF >> i) & 16'h0001) != 16'h0000;
    flag = ((16'h1154 >> i) & 16'h0001) != 16'h0000;
    if (used && !(k == 0 && flag))
      c[i] = (k == 0);
    return c;
  endfunction

  task automatic chk(input string n, input logic [15:0] s, e);
    checked++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic tally_and_finish;
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // drop every strobe
  task automatic clr;
    {pc_step, pc_jump, call_short, call_long, sub_return, irq_return} = '0;
    {irq_take, reg_we, swap_x_aux, swap_y_aux, carry_we} = '0;
    {set_carry_op, clear_carry_op, status_we, branch_done, pat_req} = '0;
    {bit_set_op, bit_reset_op, bit_test_op, memreg_req, irq_event} = '0;
  endtask
  task automatic fire;
    @(negedge core_clk);
    clr;
  endtask

  task automatic push_call(input logic sh, input logic [13:0] t);
    logic [15:0] f;
    f = exp_frame(epc, est, eca);
    @(negedge core_clk);
    call_short = sh;
    call_long = !sh;
    pc_target = t;
    fire;
    epc = sh ? (t & 14'h003F) : t;
    chk("push pc", program_counter, epc); // call target, short call masked to 003F
    chk("push we", stack_we, 1'b1); // frame saved
    chk("push base", stack_wbase, esp - 10'h003); // frame place
    chk("push frame", stack_wdata, f); // frame layout
    esp = sp_dn(esp);
    chk("push sp", stack_pointer, esp); // minus four
    chk("sp top", stack_pointer[9:6], 4'hF); // fixed bits
    frames.push_back(f);
  endtask

  task automatic pop_ret(input logic irq);
    logic [15:0] f;
    f = frames.pop_back();
    chk("pop base", stack_pop_base, {4'hF, 4'(esp[5:2] + 4'h1), 2'h0});
    @(negedge core_clk);
    sub_return = !irq;
    irq_return = irq;
    fire;
    epc = f[13:0];
    if (irq)
      {est, eca, ectl[0]} = {f[15:14], 1'b1};
    esp = {4'hF, 6'(esp[5:0] + 6'h04)};
    chk("pop pc", program_counter, epc); // pc restored
    chk("pop sp", stack_pointer, esp); // plus four
    chk("pop flags", {status_flag, carry_flag}, {est, eca}); // flags
    chk("pop ctl", int_ctrl_bits, ectl); // control bits
  endtask

  task automatic flag_op(input int k, input logic v);
    @(negedge core_clk);
    set_carry_op = (k == 0);
    clear_carry_op = (k == 1);
    carry_we = (k == 2);
    status_we = (k == 3);
    branch_done = (k == 4);
    carry_val = v;
    status_val = v;
    fire;
    eca = (k == 0) ? 1'b1 : (k == 1) ? 1'b0 : (k == 2) ? v : eca;
    est = (k == 3) ? v : (k == 4) ? 1'b1 : est;
    chk("carry", carry_flag, eca); // carry sources
    chk("status", status_flag, est); // forced after branch
  endtask

  task automatic bit_op(input int k, input logic [9:0] a, input logic [1:0] p);
    @(negedge core_clk);
    bit_set_op = (k == 0);
    bit_reset_op = (k == 1);
    bit_test_op = (k == 2);
    bit_addr = a;
    bit_pos = p;
    fire;
    if (a <= 10'h003 && k == 2)
      est = ectl[{a[1:0], p}];
    else if (a <= 10'h003)
      ectl = ctl_after(k, ectl, {a[1:0], p});
    if (a <= 10'h003 && k == 1 && {a[1:0], p} == 4'h1)
      esp = 10'h3FF;
    chk("ctl", int_ctrl_bits, ectl); // bit ops only
    chk("st", status_flag, est); // test result
    chk("sp", stack_pointer, esp); // stack reinit
  endtask

  task automatic chk_regs;
    chk("acc", acc, er[0]); // accumulator
    chk("breg", breg, er[1]); // second register
    chk("ind", ind_addr, {er[2][1:0], er[3], er[4]}); // indirect
    chk("pin", port_pin_sel, er[4]); // pin select
    chk("aux", {aux_index_hi, aux_index_lo}, {er[6], er[5]}); // pairs
  endtask

  // hang guard
  initial
  begin
    #50000;
    fail_count++;
    tally_and_finish;
  end

  // main sequence
  initial
  begin
    int k;
    int kk;
    logic [9:0] a;
    logic [15:0] f;
    logic [13:0] t;
    void'($urandom(32'h6989f72f));
    clr;
    {clk_en, carry_val, status_val, rst_n} = 4'h8;
    {pc_target, pat_addr, irq_vector, reg_sel, reg_wdata} = '0;
    {bit_addr, bit_pos, memreg_idx} = '0;
    for (k = 0; k < 7; k++)
      er[k] = 4'h0;
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    {epc, est, eca, esp, ectl} = {14'h0000, 2'b10, 10'h3FF, 16'h22A8};
    chk("rst pc", program_counter, epc); // reset vector
    chk("rst sp", stack_pointer, esp); // pointer start
    chk("rst ctl", int_ctrl_bits, ectl); // reset bits
    chk("rst fl", {status_flag, carry_flag}, {est, eca}); // flags
    // jump near the top so the steps wrap
    @(negedge core_clk);
    pc_jump = 1'b1;
    pc_target = 14'h3FFE;
    fire;
    epc = 14'h3FFE;
    repeat (2 + $urandom % 7)
    begin
      @(negedge core_clk);
      pc_step = 1'b1;
      fire;
      epc = epc + 14'h0001;
      chk("pc step", program_counter, epc); // binary counter
    end
    @(negedge core_clk);
    pc_step = 1'b1;
    clk_en = 1'b0;
    fire;
    clk_en = 1'b1;
    chk("pc hold", program_counter, epc); // frozen
    // sixteen nested levels, then unwind with both return kinds
    for (k = 0; k < 16; k++)
    begin
      flag_op(k % 5, 1'($urandom));
      push_call(k[0], 14'($urandom));
    end
    for (k = 0; k < 16; k++)
      pop_ret(k[1]);
    push_call(1'b0, 14'($urandom));
    bit_op(1, 10'h000, 2'h1);
    frames.delete();
    // hardware raises every request, software may only clear them
    @(negedge core_clk);
    irq_event = 5'h1F;
    fire;
    ectl = ectl | 16'h1154;
    chk("hw flags", int_ctrl_bits, ectl); // hardware only
    @(negedge core_clk);
    chk("masked", irq_pending, 1'b0); // masks hold requests off
    for (k = 0; k < 40; k++)
    begin
      a = 10'($urandom % 4);
      kk = $urandom % 3;
      t = 14'($urandom);
      if (kk == 2 && ((16'h33FF >> {a[1:0], t[1:0]}) & 16'h1) == 16'h0)
        kk = 0;
      bit_op(kk, a, t[1:0]);
    end
    for (k = 4; k < 12; k++)
    begin
      bit_op($urandom % 2, 10'(k), 2'($urandom));
      chk("refused", bit_refused, 1'b1); // special registers
    end
    // pending request, then interrupt entry and return
    bit_op(1, 10'h000, 2'h0);
    bit_op(1, 10'h000, 2'h3);
    @(negedge core_clk);
    irq_event = 5'h01;
    fire;
    ectl[2] = 1'b1;
    @(negedge core_clk);
    chk("no pend", irq_pending, 1'b0); // enable bit
    bit_op(0, 10'h000, 2'h0);
    @(negedge core_clk);
    chk("pend", irq_pending, 1'b1); // bit layout
    f = exp_frame(epc, est, eca);
    @(negedge core_clk);
    irq_take = 1'b1;
    irq_vector = 4'h2;
    fire;
    @(negedge core_clk);
    chk("irq we", stack_we, 1'b1); // entry push
    chk("irq frame", stack_wdata, f); // flags saved
    chk("irq ie", int_ctrl_bits[0], 1'b0); // enable cleared
    @(negedge core_clk);
    {epc, esp, ectl[0]} = {14'h0002, sp_dn(esp), 1'b0};
    frames.push_back(f);
    chk("irq pc", program_counter, epc); // vector entry
    chk("irq sp", stack_pointer, esp); // minus four
    flag_op(2, ~f[14]);
    flag_op(3, ~f[15]);
    pop_ret(1'b1);
    // pattern reach and memory registers
    for (k = 0; k < 6; k++)
    begin
      t = (k == 0) ? 14'h0FFF : (k == 1) ? 14'h1000 : 14'($urandom);
      @(negedge core_clk);
      pat_req = 1'b1;
      pat_addr = t;
      fire;
      chk("pat", pat_ok, t <= 14'h0FFF); // pattern area
    end
    for (k = 0; k < 16; k++)
    begin
      @(negedge core_clk);
      memreg_req = 1'b1;
      memreg_idx = 4'(k);
      fire;
      chk("mr valid", memreg_valid, 1'b1); // memory registers
      chk("mr addr", memreg_addr, 10'h020 + 10'(k)); // base
    end
    // working registers and auxiliary exchange
    for (k = 0; k < 23; k++)
    begin
      @(negedge core_clk);
      reg_we = (k < 21);
      swap_x_aux = (k == 21);
      swap_y_aux = (k == 22);
      reg_sel = 3'(k % 7);
      reg_wdata = 4'($urandom);
      fire;
      if (k < 21)
        er[k % 7] = (k % 7 == 2) ? (reg_wdata & 4'h3) : reg_wdata;
      else if (k == 21)
        {er[3], er[5]} = {er[5], er[3]};
      else
        {er[4], er[6]} = {er[6], er[4]};
      chk_regs;
    end
    tally_and_finish;
  end
endmodule
